/* File: src/sabi_top.v */
// sabi_top.v - digital control of the successive approximation converter
// behind an 8-bit parallel host port: setup latch, half-rate sequencer,
// approximation register, done line and two-byte result readout.
// assumes host strobes already synchronous to clk; analog side supplies the
// comparator decision and takes the trial word, channel bits and track line.
//
// Summary of operation
// - select and write low capture data byte
// - low five bits pick multiplexer channel
// - bit five picks unsigned or signed
// - bit six picks 8 or 10 bits
// - bit seven picks left or right justify
// - write strobe release sets start flag
// - acquire six clocks from half-rate falling edge
// - convert 16, 18, 20 or 22 clocks
// - done falls only on half-rate falling edge
// - start in rising phase waits longer
// - done low when result is ready
// - first read gives byte one, clears done
// - second read gives byte two
// - new start allowed before second read
// - select, write, read low restarts unchanged
// - host accesses need no clock phase
// - select held low works, strobes frame
// - start at first rise of write or select
// - drive data only during select and read
// - result reformatted before reaching data lines
// - unsigned negative input gives zero code
`timescale 1ns/100ps
`include "sabi_regs.vh"

module sabi_top (
    input  wire        clk,
    input  wire        rst,
    input  wire        cs_n,
    input  wire        wr_n,
    input  wire        rd_n,
    input  wire [7:0]  parallel_data_lines_in,
    output wire [7:0]  parallel_data_lines_out,
    output wire        parallel_data_lines_oe,
    output wire        done_n,
    output wire [4:0]  channel_select_bits,
    output wire        track_hold,
    output wire [10:0] dac_trial,
    input  wire        cmp_in
);

    // ======================================================================
    // states
    // ======================================================================
    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_WAIT = 4'b0010;
    localparam [3:0] S_ACQ  = 4'b0100;
    localparam [3:0] S_CONV = 4'b1000;

    // ======================================================================
    // declarations
    // ======================================================================
    reg  [3:0]  state_reg;
    reg  [3:0]  state_next;
    reg  [4:0]  cnt_reg;
    reg  [4:0]  cnt_next;
    reg  [3:0]  bit_reg;
    reg  [3:0]  bit_next;
    reg  [10:0] sar_reg;
    reg  [10:0] sar_next;
    reg  [10:0] result_reg;
    reg         half_reg;
    reg         start_reg;
    reg         done_n_reg;
    reg         byte_sel_reg;
    reg  [7:0]  data_out_reg;
    reg  [7:0]  setup_reg;
    reg  [7:0]  shadow_reg;
    reg         combined_reg;
    reg         wr_act_reg;
    reg         rd_act_reg;
    reg  [4:0]  conv_len;
    reg  [3:0]  nbits;
    wire        wr_act;
    wire        rd_act;
    wire        wr_end;
    wire        rd_begin;
    wire        rd_end;
    wire        half_fall;
    wire        conv_last;
    wire [7:0]  fmt_one;
    wire [7:0]  fmt_two;

    // ======================================================================
    // host port decode
    // ======================================================================
    // strobes framed by select; a select held low leaves the strobes alone
    assign wr_act   = ~cs_n & ~wr_n;
    assign rd_act   = ~cs_n & ~rd_n;
    // first of write or select to rise ends the write frame
    assign wr_end   = wr_act_reg & ~wr_act;
    assign rd_begin = rd_act & ~rd_act_reg;
    assign rd_end   = rd_act_reg & ~rd_act;

    // frame history; no phase relation to the sequencer is assumed
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_act_reg <= 1'b0;
            rd_act_reg <= 1'b0;
        end else begin
            wr_act_reg <= wr_act;
            rd_act_reg <= rd_act;
        end
    end

    // ======================================================================
    // setup latch
    // ======================================================================
    // byte is sampled while the strobe is low and committed at its release;
    // a read seen anywhere in the frame marks a restart with setup kept
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            shadow_reg   <= `SABI_SETUP_RESET;
            combined_reg <= 1'b0;
            setup_reg    <= `SABI_SETUP_RESET;
        end else begin
            if (wr_act && !wr_act_reg) begin
                combined_reg <= ~rd_n;
            end else if (wr_act && !rd_n) begin
                combined_reg <= 1'b1;
            end
            if (wr_act && rd_n) begin
                shadow_reg <= parallel_data_lines_in;
            end
            if (wr_end && !combined_reg && rd_n) begin
                setup_reg <= shadow_reg;
            end
        end
    end

    assign channel_select_bits = setup_reg[`SABI_MUX_MSB:`SABI_MUX_LSB];

    // ======================================================================
    // resolution decode
    // ======================================================================
    // bit six high means 8 bits, bit five high means unsigned
    always @* begin
        case ({setup_reg[`SABI_RES8_BIT], setup_reg[`SABI_UNSIGNED_BIT]})
            2'b11: begin
                conv_len = `SABI_CONV_8;
                nbits    = `SABI_BITS_8;
            end
            2'b10: begin
                conv_len = `SABI_CONV_8S;
                nbits    = `SABI_BITS_8S;
            end
            2'b01: begin
                conv_len = `SABI_CONV_10;
                nbits    = `SABI_BITS_10;
            end
            default: begin
                conv_len = `SABI_CONV_10S;
                nbits    = `SABI_BITS_10S;
            end
        endcase
    end

    // ======================================================================
    // half-rate clock and start flag
    // ======================================================================
    // the half-rate clock is a free toggle; its falling edge is the edge
    // on which half_reg goes from one to zero
    assign half_fall = half_reg;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            half_reg <= 1'b0;
        end else begin
            half_reg <= ~half_reg;
        end
    end

    // flag stays set until the sequencer takes it; a new start set in the
    // same cycle as the take wins, so no request is lost
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            start_reg <= 1'b0;
        end else if (wr_end) begin
            start_reg <= 1'b1;
        end else if (state_reg == S_WAIT && half_fall) begin
            start_reg <= 1'b0;
        end
    end

    // ======================================================================
    // sequencer
    // ======================================================================
    assign conv_last = (cnt_reg == conv_len - 5'h01);

    // one decision per half-rate period, taken in its second clock; a
    // comparator that never passes leaves an all-zero word, which is how a
    // reversed input reads in unsigned mode
    always @* begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        bit_next   = bit_reg;
        sar_next   = sar_reg;
        case (state_reg)
            S_IDLE: begin
                if (start_reg) begin
                    state_next = S_WAIT;
                end
            end
            S_WAIT: begin
                // a flag met in the rising phase sits out the extra phase
                if (half_fall && start_reg) begin
                    state_next = S_ACQ;
                    cnt_next   = 5'h00;
                end
            end
            S_ACQ: begin
                cnt_next = cnt_reg + 5'h01;
                if (cnt_reg == `SABI_ACQ_CYCLES - 5'h01) begin
                    state_next = S_CONV;
                    cnt_next   = 5'h00;
                    bit_next   = nbits - 4'h1;
                    sar_next   = 11'h000;
                    sar_next[nbits - 4'h1] = 1'b1;
                end
            end
            S_CONV: begin
                cnt_next = cnt_reg + 5'h01;
                if (cnt_reg[0]) begin
                    sar_next[bit_reg] = cmp_in;
                    if (bit_reg != 4'h0) begin
                        sar_next[bit_reg - 4'h1] = 1'b1;
                        bit_next = bit_reg - 4'h1;
                    end
                end
                if (conv_last) begin
                    state_next = S_IDLE;
                end
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
        // a start during a conversion abandons it and begins again
        if (wr_end && state_reg != S_IDLE && state_reg != S_WAIT) begin
            state_next = S_WAIT;
        end
    end

    // sequencer registers
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= S_IDLE;
            cnt_reg   <= 5'h00;
            bit_reg   <= 4'h0;
            sar_reg   <= 11'h000;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            bit_reg   <= bit_next;
            sar_reg   <= sar_next;
        end
    end

    assign track_hold = (state_reg == S_ACQ);
    assign dac_trial  = sar_reg;

    // ======================================================================
    // result, done line and byte pointer
    // ======================================================================
    // the conversion ends on a half-rate falling edge since acquisition and
    // every conversion length are even; end of conversion wins over a read
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            result_reg   <= 11'h000;
            done_n_reg   <= 1'b1;
            byte_sel_reg <= 1'b0;
        end else if (state_reg == S_CONV && conv_last && !wr_end) begin
            result_reg   <= sar_next;
            done_n_reg   <= 1'b0;
            byte_sel_reg <= 1'b0;
        end else begin
            if (rd_begin) begin
                done_n_reg <= 1'b1;
            end
            if (rd_end && !wr_act_reg) begin
                byte_sel_reg <= ~byte_sel_reg;
            end
        end
    end

    assign done_n = done_n_reg;

    // ======================================================================
    // output decoder and data lines
    // ======================================================================
    sabi_fmt u_fmt (
        .code          (result_reg),
        .res8          (setup_reg[`SABI_RES8_BIT]),
        .unsigned_mode (setup_reg[`SABI_UNSIGNED_BIT]),
        .left_just     (setup_reg[`SABI_LEFT_BIT]),
        .byte_one      (fmt_one),
        .byte_two      (fmt_two)
    );

    // registered, so data is valid one clock after the read frame opens
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            data_out_reg <= 8'h00;
        end else begin
            data_out_reg <= byte_sel_reg ? fmt_two : fmt_one;
        end
    end

    assign parallel_data_lines_out = data_out_reg;
    assign parallel_data_lines_oe  = rd_act;

endmodule // sabi_top

/* File: src/sabi_regs.vh */
// sabi_regs.vh - constants of the converter bus interface: setup word fields,
// reset values and sequencer cycle counts.
// assumes inclusion by bare name from the design files; definitions only.
`ifndef SABI_REGS_VH
`define SABI_REGS_VH

// ==========================================================================
// setup word fields
// ==========================================================================
`define SABI_MUX_LSB        0
`define SABI_MUX_MSB        4
`define SABI_UNSIGNED_BIT   5
`define SABI_RES8_BIT       6
`define SABI_LEFT_BIT       7
`define SABI_SETUP_RESET    8'h00

// ==========================================================================
// sequencer timing, in input clock cycles
// ==========================================================================
`define SABI_ACQ_CYCLES     5'h06
`define SABI_CONV_8         5'h10
`define SABI_CONV_8S        5'h12
`define SABI_CONV_10        5'h14
`define SABI_CONV_10S       5'h16

// ==========================================================================
// result widths in bits, sign included
// ==========================================================================
`define SABI_BITS_8         4'h8
`define SABI_BITS_8S        4'h9
`define SABI_BITS_10        4'hA
`define SABI_BITS_10S       4'hB

`endif

/* File: src/sabi_fmt.v */
// sabi_fmt.v - output decoder: turns the final approximation word into the
// two result bytes for the programmed resolution, signedness and justification.
// assumes the code arrives right aligned, offset binary in signed mode.
`timescale 1ns/100ps
`include "sabi_regs.vh"

module sabi_fmt (
    input  wire [10:0] code,
    input  wire        res8,
    input  wire        unsigned_mode,
    input  wire        left_just,
    output reg  [7:0]  byte_one,
    output reg  [7:0]  byte_two
);

    // ======================================================================
    // width of the code and conversion to two's complement
    // ======================================================================
    reg [10:0] val;
    reg [15:0] word;
    reg        sx;

    // signed codes come out of the search as offset binary; flipping the
    // top bit gives two's complement without an adder
    always @* begin
        val  = code;
        sx   = 1'b0;
        word = 16'h0000;
        case ({res8, unsigned_mode})
            2'b11: begin
                word = left_just ? {code[7:0], 8'h00} : {8'h00, code[7:0]};
            end
            2'b10: begin
                val[8] = ~code[8];
                sx     = val[8];
                word   = left_just ? {val[8:0], 7'h00} : {{7{sx}}, val[8:0]};
            end
            2'b01: begin
                word = left_just ? {code[9:0], 6'h00} : {6'h00, code[9:0]};
            end
            default: begin
                val[10] = ~code[10];
                sx      = val[10];
                word    = left_just ? {val[10:0], 5'h00} : {{5{sx}}, val[10:0]};
            end
        endcase
        byte_one = word[15:8];
        byte_two = word[7:0];
    end

endmodule // sabi_fmt

/* File: verif/sabi_afe_model.sv */
// sabi_afe_model.sv - analog side of the converter: a comparator that judges
// each trial word of the approximation register against a target code.
// assumes the bench sets the target before a conversion starts.
`timescale 1ns/100ps

// ==========================================================================
// comparator model
// ==========================================================================
module sabi_afe_model (
    input  wire [10:0] dac_trial,
    input  wire [10:0] target,
    output wire        cmp_in
);
    // keep the trial bit while the trial does not overshoot; a negative
    // input in unsigned mode is a target of zero, so every bit is dropped
    assign cmp_in = (dac_trial <= target);
endmodule // sabi_afe_model

/* File: verif/sabi_top_sva.sv */
// sabi_top_sva.sv - concurrent checks on the host port, sequencer and done line.
// assumes it is bound to sabi_top and sees only its ports.
`timescale 1ns/100ps

// ==========================================================================
// checker
// ==========================================================================
module sabi_top_sva (
    input wire       clk,
    input wire       rst,
    input wire       cs_n,
    input wire       wr_n,
    input wire       rd_n,
    input wire [7:0] parallel_data_lines_in,
    input wire       parallel_data_lines_oe,
    input wire       done_n,
    input wire [4:0] channel_select_bits,
    input wire       track_hold
);
    reg  [7:0] setup_reg;
    reg  [5:0] conv_cnt_reg;
    reg        ph_reg;
    reg        fall_ph_reg;
    reg        seen_reg;
    wire       wr_act   = !cs_n && !wr_n;
    wire [5:0] conv_len = 6'h16 - {setup_reg[6], 2'h0} - {setup_reg[5], 1'h0};

    // shadow setup, conversion cycle count and a free-running parity bit
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            setup_reg   <= 8'h00;
            conv_cnt_reg <= 6'h00;
            ph_reg      <= 1'b0;
            fall_ph_reg <= 1'b0;
            seen_reg    <= 1'b0;
        end else begin
            ph_reg   <= ~ph_reg;
            conv_cnt_reg <= $fell(track_hold) ? 6'h01 : conv_cnt_reg + 6'h01;
            if (wr_act && rd_n)
                setup_reg <= parallel_data_lines_in;
            if ($fell(done_n)) begin
                fall_ph_reg <= ph_reg;
                seen_reg    <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_oe_window: assert property (parallel_data_lines_oe == (!cs_n && !rd_n))
        else $error("data lines driven outside a read");
    a_track_six: assert property ($rose(track_hold) |-> track_hold [*6] ##1 !track_hold)
        else $error("acquisition not six cycles");
    a_conv_len: assert property ($fell(done_n) |-> conv_cnt_reg == conv_len)
        else $error("conversion length wrong for resolution");
    a_done_phase: assert property ($fell(done_n) && seen_reg |-> ph_reg == fall_ph_reg)
        else $error("done fell off the half-rate phase");
    a_acq_phase: assert property ($rose(track_hold) && seen_reg |-> ph_reg == fall_ph_reg)
        else $error("acquisition began off the half-rate falling edge");
    a_start_wait: assert property ($fell(wr_act) && rd_n && !track_hold |-> ##[2:5] $rose(track_hold))
        else $error("write end did not start acquisition");
    a_chan_bits: assert property ($fell(wr_act) && rd_n |=> channel_select_bits == setup_reg[4:0])
        else $error("channel bits differ from setup");
    a_done_clear: assert property (!done_n && $rose(!cs_n && !rd_n) |=> done_n)
        else $error("read did not clear done");
    a_done_holds: assert property (!done_n && (cs_n || rd_n) |=> !done_n)
        else $error("done released without a read");
endmodule // sabi_top_sva

bind sabi_top sabi_top_sva u_sva (
    .clk(clk), .rst(rst), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .parallel_data_lines_in(parallel_data_lines_in),
    .parallel_data_lines_oe(parallel_data_lines_oe), .done_n(done_n),
    .channel_select_bits(channel_select_bits), .track_hold(track_hold)
);

/* File: verif/tb_sar_adc_bus_interface.sv */
// tb_sar_adc_bus_interface.sv - self-checking bench for the converter host port.
// assumes sabi_top as declared and the comparator model on the analog side.
`timescale 1ns/100ps
module tb_sar_adc_bus_interface;
    // ======================================================================
    // pins and bench state
    // ======================================================================
    reg         clk, rst, cs_n, wr_n, rd_n, cs_idle, cs_first;
    reg  [7:0]  din, cur;
    reg  [10:0] target;
    reg  [15:0] lfsr, e;
    wire [7:0]  dout;
    wire        oe, done_n, track_hold, cmp_in;
    wire [4:0]  chan;
    wire [10:0] trial;
    reg  [7:0]  exp_q[$];
    integer     failures, checks, run, i, k;

    sabi_top dut (.clk(clk), .rst(rst), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
        .parallel_data_lines_in(din), .parallel_data_lines_out(dout),
        .parallel_data_lines_oe(oe), .done_n(done_n), .channel_select_bits(chan),
        .track_hold(track_hold), .dac_trial(trial), .cmp_in(cmp_in));
    sabi_afe_model afe (.dac_trial(trial), .target(target), .cmp_in(cmp_in));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ======================================================================
    // helpers
    // ======================================================================
    function [15:0] nxt(input [15:0] x);
        nxt = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    function integer wid(input [7:0] s);
        wid = (s[6] ? 8 : 10) + (s[5] ? 0 : 1);
    endfunction

    // expected 16-bit word; signed codes turn from offset to two's complement
    function [15:0] fmt(input [7:0] s, input [10:0] t);
        reg [15:0] c;
        begin
            c = {5'h00, t};
            if (!s[5]) c = c ^ (16'h0001 << (wid(s) - 1));
            if (s[7]) c = c << (16 - wid(s));
            else if (!s[5] && c[wid(s) - 1]) c = c | (16'hFFFF << wid(s));
            fmt = c;
        end
    endfunction

    task chk(input string nm, input [15:0] ex, input [15:0] sn);
        begin
            checks = checks + 1;
            if (sn !== ex) begin
                failures = failures + 1;
                $display("MISMATCH %s expected %h seen %h", nm, ex, sn);
            end
        end
    endtask

    task print_verdict;
        begin
            if (failures == 0 && checks > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask

    // ======================================================================
    // host bus cycles
    // ======================================================================
    // comb keeps read low too; the bus is turned to the inverse one clock after the frame ends
    task wr(input [7:0] d, input comb);
        begin
            @(negedge clk);
            cs_n = 1'b0; wr_n = 1'b0; rd_n = ~comb; din = d;
            repeat (2) @(negedge clk);
            if (cs_first) cs_n = 1'b1; else wr_n = 1'b1;
            rd_n = 1'b1;
            @(negedge clk);
            wr_n = 1'b1; cs_n = cs_idle; din = ~d;
            if (!comb) cur = d;
        end
    endtask

    task rd(input [7:0] ex);
        begin
            exp_q.push_back(ex);
            @(negedge clk);
            cs_n = 1'b0; rd_n = 1'b0;
            repeat (3) @(negedge clk);
            rd_n = 1'b1; cs_n = cs_idle;
            @(negedge clk);
            chk("oe", 16'h0000, oe);
            chk("done_n", 16'h0001, done_n);
        end
    endtask

    // start a conversion and wait for done under a bound
    task conv(input [7:0] s, input comb, input [10:0] raw);
        begin
            target = raw & (11'h7FF >> (11 - wid(comb ? cur : s)));
            wr(s, comb);
            k = 0;
            while (done_n !== 1'b0 && k < 80) begin
                @(negedge clk);
                k = k + 1;
            end
            chk("done_n", 16'h0000, done_n);
            chk("chan", cur[4:0], chan);
            e = fmt(cur, target);
        end
    endtask

    // result watcher: a read byte is settled on the second cycle of the frame
    always @(posedge clk) begin
        #2;
        run = (oe === 1'b1 && wr_n) ? run + 1 : 0;
        if (run == 2) chk("rdata", exp_q.pop_front(), dout);
    end

    // ======================================================================
    // main sequence
    // ======================================================================
    initial begin
        rst = 1'b1; cs_n = 1'b1; wr_n = 1'b1; rd_n = 1'b1; din = 8'h00;
        target = 11'h000; cur = 8'h00; cs_idle = 1'b1; cs_first = 1'b0;
        lfsr = 16'h13CA; failures = 0; checks = 0; run = 0; e = 16'h0000;
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        // every format code; select held low on half; staggered write phase
        for (i = 0; i < 8; i = i + 1) begin
            lfsr = nxt(lfsr);
            cs_idle = ~i[1];
            cs_first = (i == 5);
            repeat (i) @(negedge clk);
            conv({i[2:0], lfsr[4:0]}, 1'b0, (i == 1) ? 11'h000 : lfsr[15:5]);
            rd(e[15:8]);
            rd(e[7:0]);
            rd(e[15:8]);
        end
        // restart before the second read, then a combined restart
        cs_first = 1'b0;
        conv(8'hA3, 1'b0, lfsr[10:0]);
        rd(e[15:8]);
        lfsr = nxt(lfsr);
        conv(8'h5C, 1'b1, lfsr[10:0]);
        rd(e[15:8]);
        rd(e[7:0]);
        // a write in mid-conversion abandons it; only the second result counts
        wr(8'h00, 1'b0);
        repeat (12) @(negedge clk);
        lfsr = nxt(lfsr);
        conv(8'hC7, 1'b0, lfsr[10:0]);
        rd(e[15:8]);
        rd(e[7:0]);
        print_verdict;
    end

    // watchdog well beyond the few hundred cycles the tests take
    initial begin
        #200000;
        failures = failures + 1;
        print_verdict;
    end
endmodule // tb_sar_adc_bus_interface
